// ### design/xpe_pkg.sv
// Overview of operation
// [RL1] Quad XiP dummy clock count comes from status register five bits 6:4.
// [RL2] Field codes 000..100 give 2, 4, 6, 8 and 10 dummy clocks.
// [RL3] Dummy count already covers the two clocks of the mode byte.
// [RL4] Alignment flag at status five bit 0 joins opcode in alignment selection.
// [RL5] EBh runs aligned when the alignment flag is one, unaligned when zero.
// [RL6] E7h is always aligned and ignores the alignment flag.
// [RL7] Host keeps SCK within the listed limit for its read setup.
// [RL8] In wrap mode the host uses the lower wrap-mode frequency limits.
// [RL9] Page erase opcode is 81h or DBh, eight bits on SI, MSB first.
// [RL10] Write enable 06h must set the write latch before page erase is accepted.
// [RL11] Page erase carries opcode and address on SI only, no data phase.
// [RL12] Three address bytes follow over 24 clocks, bit 23 first.
// [RL13] Page index is address bits 21:8; bits 23:22 and 7:0 ignored.
// [RL14] Rising chip select after a valid page erase starts erasing that page.
// [RL15] Under active status interrupt 25h, SO carries the busy flag.
// [RL16] SO is refreshed on every SCK cycle while it carries busy.
// [RL17] Host treats SO falling from one to zero as erase completion.
// [RL18] Busy flag at status byte one bit 0 reads busy during the erase.
// [RL19] Write latch is cleared before the page erase finishes.
// [RL20] Chip select rising mid-byte aborts page erase with no action.
// [RL21] Fewer than three full address bytes before chip select rises aborts erase.
// [RL22] Protected target: no erase, return to idle on chip select rise.
// [RL23] Aligned quad read treats address bits 1:0 as zero.
// [RL24] Page erase with write latch clear is ignored; array and busy untouched.
// [RL25] Dummy codes 101..111 are reserved and give the largest count.
`default_nettype none
package xpe_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_PAGE_ERASE_A = 8'h81;
  localparam logic [7:0] OP_PAGE_ERASE_B = 8'hDB;
  localparam logic [7:0] OP_STATUS_IRQ = 8'h25;
  localparam logic [7:0] OP_XIP_READ = 8'hEB;
  localparam logic [7:0] OP_XIP_READ_ALIGNED = 8'hE7;

  localparam int DC_MSB = 6;
  localparam int DC_LSB = 4;
  localparam int ALIGN_BIT = 0;
  localparam int SR1_BUSY_BIT = 0;
  localparam int SR1_LATCH_BIT = 1;

  localparam logic [2:0] DC_CODE_2 = 3'h0;
  localparam logic [2:0] DC_CODE_4 = 3'h1;
  localparam logic [2:0] DC_CODE_6 = 3'h2;
  localparam logic [2:0] DC_CODE_8 = 3'h3;
  localparam logic [2:0] DC_CODE_10 = 3'h4;
  localparam logic [3:0] DUMMY_2 = 4'h2;
  localparam logic [3:0] DUMMY_4 = 4'h4;
  localparam logic [3:0] DUMMY_6 = 4'h6;
  localparam logic [3:0] DUMMY_8 = 4'h8;
  localparam logic [3:0] DUMMY_10 = 4'hA;

  localparam int PAGE_MSB = 21;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_W = PAGE_MSB - PAGE_LSB + 1;
  localparam int ADDR_W = 24;
  localparam int ALIGN_LSBS = 2;

  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_SERIAL_ADDR = 6'h20;
  localparam logic [5:0] BITS_SAT = 6'h3F;
  localparam logic [2:0] QUAD_ADDR_NIBBLES = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_SERIAL = 3'b010,
    ST_QUAD_ADDR = 3'b011,
    ST_QUAD_DUMMY = 3'b100,
    ST_STATUS_IRQ = 3'b101,
    ST_IGNORE = 3'b110
  } xpe_state_t;
endpackage
`default_nettype wire

// ### design/xpe_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module xpe_sequencer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io_in,
  output logic spi_so_out,
  output logic spi_so_oe,
  input wire logic [7:0] status_five,
  input wire logic page_protected,
  input wire logic erase_done,
  output logic erase_start,
  output logic [xpe_pkg::PAGE_W-1:0] erase_page,
  output logic [7:0] status_byte_one,
  output logic busy_flag,
  output logic write_latch_flag,
  output logic xip_active,
  output logic xip_aligned,
  output logic [3:0] xip_dummy_clocks,
  output logic [xpe_pkg::ADDR_W-1:0] xip_addr,
  output logic xip_addr_valid,
  output logic xip_dummy_done
);
  localparam int PIN_W = 6;
  // Idle levels: chip select high, clock and data low, so no false edge after reset
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h02;

  // Pins come from the host's domain: two flops before any logic
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic sck_prev;
  logic cs_prev;

  assign pin_raw = {spi_io_in, spi_cs_n, spi_sck};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          pin_meta[gi] <= PIN_IDLE[gi];
          pin_sync[gi] <= PIN_IDLE[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic sck_s;
  logic cs_n_s;
  logic [3:0] io_s;
  assign sck_s = pin_sync[0];
  assign cs_n_s = pin_sync[1];
  assign io_s = pin_sync[5:2];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      cs_prev <= cs_n_s;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  assign sck_rise = sck_s & ~sck_prev & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_prev & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_prev;
  assign cs_rise = cs_n_s & ~cs_prev;

  // Dummy count selection
  function automatic logic [3:0] dummy_for(input logic [2:0] code);
    logic [3:0] n;
    n = xpe_pkg::DUMMY_10;
    case (code)
      xpe_pkg::DC_CODE_2: n = xpe_pkg::DUMMY_2;
      xpe_pkg::DC_CODE_4: n = xpe_pkg::DUMMY_4;
      xpe_pkg::DC_CODE_6: n = xpe_pkg::DUMMY_6;
      xpe_pkg::DC_CODE_8: n = xpe_pkg::DUMMY_8;
      xpe_pkg::DC_CODE_10: n = xpe_pkg::DUMMY_10;
      // Reserved codes fall back to the safest, longest wait
      default: n = xpe_pkg::DUMMY_10;
    endcase
    return n;
  endfunction

  xpe_pkg::xpe_state_t state;
  xpe_pkg::xpe_state_t next_state;
  logic [5:0] bit_cnt;
  logic [31:0] shift_in;
  logic [7:0] opcode;
  logic [2:0] nib_cnt;
  logic [3:0] dummy_cnt;
  logic is_erase_op;
  logic opcode_done;
  logic serial_done;

  assign opcode_done = sck_rise && (bit_cnt == xpe_pkg::BITS_OPCODE - 6'h01);
  assign is_erase_op = (opcode == xpe_pkg::OP_PAGE_ERASE_A) || (opcode == xpe_pkg::OP_PAGE_ERASE_B); // see [RL9]
  assign serial_done = bit_cnt == xpe_pkg::BITS_SERIAL_ADDR;

  // Bits clocked this frame, saturating so long frames never alias a boundary
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cs_fall) begin
      bit_cnt <= 6'h00;
    end else if (sck_rise && bit_cnt != xpe_pkg::BITS_SAT) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // SI shifted MSB first on rising SCK
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_in <= 32'h0000_0000;
    end else if (sck_rise && (state == xpe_pkg::ST_OPCODE || state == xpe_pkg::ST_SERIAL)) begin
      shift_in <= {shift_in[30:0], io_s[0]}; // see [RL9] see [RL12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      opcode <= 8'h00;
    end else if (opcode_done) begin
      opcode <= {shift_in[6:0], io_s[0]};
    end
  end

  always_comb begin
    logic [7:0] op_now;
    op_now = {shift_in[6:0], io_s[0]};
    next_state = state;
    case (state)
      xpe_pkg::ST_IDLE: begin
        if (cs_fall) begin
          next_state = xpe_pkg::ST_OPCODE;
        end
      end
      xpe_pkg::ST_OPCODE: begin
        if (opcode_done) begin
          case (op_now)
            xpe_pkg::OP_PAGE_ERASE_A, xpe_pkg::OP_PAGE_ERASE_B: begin
              // Busy device or clear latch: drop the command untouched
              if (write_latch_flag && !busy_flag) begin
                next_state = xpe_pkg::ST_SERIAL; // see [RL10] see [RL24]
              end else begin
                next_state = xpe_pkg::ST_IGNORE; // see [RL24]
              end
            end
            xpe_pkg::OP_XIP_READ, xpe_pkg::OP_XIP_READ_ALIGNED: next_state = xpe_pkg::ST_QUAD_ADDR;
            xpe_pkg::OP_STATUS_IRQ: next_state = xpe_pkg::ST_STATUS_IRQ; // see [RL15]
            xpe_pkg::OP_WRITE_ENABLE: next_state = xpe_pkg::ST_IGNORE;
            default: next_state = xpe_pkg::ST_IGNORE;
          endcase
        end
      end
      xpe_pkg::ST_QUAD_ADDR: begin
        if (sck_rise && nib_cnt == xpe_pkg::QUAD_ADDR_NIBBLES - 3'h1) begin
          next_state = xpe_pkg::ST_QUAD_DUMMY;
        end
      end
      xpe_pkg::ST_SERIAL, xpe_pkg::ST_QUAD_DUMMY, xpe_pkg::ST_STATUS_IRQ, xpe_pkg::ST_IGNORE: begin
        next_state = state;
      end
      default: next_state = xpe_pkg::ST_IDLE;
    endcase
    if (cs_rise) begin
      next_state = xpe_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= xpe_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Page erase commit on chip select rise
  logic erase_ok;
  logic frame_is_wren;
  // Whole bytes only, full address, no more than the 1-1-0 frame
  assign erase_ok = cs_rise && state == xpe_pkg::ST_SERIAL && is_erase_op
                    && serial_done && !page_protected; // see [RL11] see [RL20] see [RL21] see [RL22]
  assign frame_is_wren = cs_rise && state == xpe_pkg::ST_IGNORE
                         && opcode == xpe_pkg::OP_WRITE_ENABLE && bit_cnt == xpe_pkg::BITS_OPCODE;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      erase_start <= 1'b0;
    end else begin
      erase_start <= erase_ok; // see [RL14]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      erase_page <= '0;
    end else if (erase_ok) begin
      erase_page <= shift_in[xpe_pkg::PAGE_MSB:xpe_pkg::PAGE_LSB]; // see [RL13]
    end
  end

  // Busy from accepted erase until the array reports completion
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_flag <= 1'b0;
    end else if (erase_ok) begin
      busy_flag <= 1'b1; // see [RL18]
    end else if (erase_done) begin
      busy_flag <= 1'b0;
    end
  end

  // Latch drops as the erase begins, well before it ends
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      write_latch_flag <= 1'b0;
    end else if (frame_is_wren && !busy_flag) begin
      write_latch_flag <= 1'b1; // see [RL10]
    end else if (erase_ok) begin
      write_latch_flag <= 1'b0; // see [RL19]
    end
  end

  always_comb begin
    status_byte_one = 8'h00;
    status_byte_one[xpe_pkg::SR1_BUSY_BIT] = busy_flag; // see [RL18]
    status_byte_one[xpe_pkg::SR1_LATCH_BIT] = write_latch_flag;
  end

  // Busy mirrored onto SO, refreshed each falling SCK
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spi_so_out <= 1'b0;
    end else if (next_state == xpe_pkg::ST_STATUS_IRQ && (state != xpe_pkg::ST_STATUS_IRQ || sck_fall)) begin
      spi_so_out <= busy_flag; // see [RL15] see [RL16] see [RL17]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spi_so_oe <= 1'b0;
    end else begin
      spi_so_oe <= next_state == xpe_pkg::ST_STATUS_IRQ; // see [RL15]
    end
  end

  // Quad read setup
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      xip_active <= 1'b0;
      xip_aligned <= 1'b0;
      xip_dummy_clocks <= xpe_pkg::DUMMY_2;
    end else if (cs_rise) begin
      xip_active <= 1'b0;
    end else if (opcode_done && next_state == xpe_pkg::ST_QUAD_ADDR) begin
      xip_active <= 1'b1;
      // Mode byte clocks are inside this count, nothing added
      xip_dummy_clocks <= dummy_for(status_five[xpe_pkg::DC_MSB:xpe_pkg::DC_LSB]); // see [RL1] see [RL2] see [RL3] see [RL25]
      xip_aligned <= ({shift_in[6:0], io_s[0]} == xpe_pkg::OP_XIP_READ_ALIGNED)
                     || status_five[xpe_pkg::ALIGN_BIT]; // see [RL4] see [RL5] see [RL6]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || cs_fall) begin
      nib_cnt <= 3'h0;
    end else if (sck_rise && state == xpe_pkg::ST_QUAD_ADDR) begin
      nib_cnt <= nib_cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      xip_addr <= '0;
      xip_addr_valid <= 1'b0;
    end else if (cs_fall) begin
      xip_addr_valid <= 1'b0;
    end else if (sck_rise && state == xpe_pkg::ST_QUAD_ADDR) begin
      xip_addr <= {xip_addr[xpe_pkg::ADDR_W-5:0], io_s};
      xip_addr_valid <= nib_cnt == xpe_pkg::QUAD_ADDR_NIBBLES - 3'h1;
    end else if (xip_addr_valid && xip_aligned) begin
      xip_addr[xpe_pkg::ALIGN_LSBS-1:0] <= '0; // see [RL23]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || cs_fall) begin
      dummy_cnt <= 4'h0;
      xip_dummy_done <= 1'b0;
    end else if (sck_rise && state == xpe_pkg::ST_QUAD_DUMMY && !xip_dummy_done) begin
      dummy_cnt <= dummy_cnt + 4'h1;
      xip_dummy_done <= dummy_cnt + 4'h1 == xip_dummy_clocks; // see [RL3]
    end
  end
endmodule // xpe_sequencer
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic sys_clk;
  logic sys_rst;
  logic [7:0] status_five;
  logic page_protected;
  logic erase_done;
  logic spi_sck;
  logic spi_cs_n;
  logic [3:0] spi_io;
  logic spi_so_out;
  logic spi_so_oe;
  logic erase_start;
  logic [xpe_pkg::PAGE_W-1:0] erase_page;
  logic [7:0] status_byte_one;
  logic busy_flag;
  logic write_latch_flag;
  logic xip_active;
  logic xip_aligned;
  logic [3:0] xip_dummy_clocks;
  logic [xpe_pkg::ADDR_W-1:0] xip_addr;
  logic xip_addr_valid;
  logic xip_dummy_done;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 32'hed33;
  int cyc = 0;
  int lens[5] = '{31, 24, 40, 32, 32};
  logic [xpe_pkg::PAGE_W-1:0] exp_q[$];
  xpe_sequencer xpe_sequencer_i (.sys_clk, .sys_rst, .spi_sck, .spi_cs_n, .spi_io_in(spi_io), .spi_so_out,
    .spi_so_oe, .status_five, .page_protected, .erase_done, .erase_start, .erase_page, .status_byte_one,
    .busy_flag, .write_latch_flag, .xip_active, .xip_aligned, .xip_dummy_clocks, .xip_addr, .xip_addr_valid,
    .xip_dummy_done);
  xpe_host xpe_host_i (.sys_clk, .spi_sck, .spi_cs_n, .spi_io);
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
    xpe_host_i.open();
    xpe_host_i.shift({op, a, 8'h00}, n, 1'h0);
    xpe_host_i.close();
  endtask
  task automatic done_pulse();
    erase_done <= 1'h1;
    @(posedge sys_clk);
    erase_done <= 1'h0;
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (erase_start === 1'h1) begin
      if (exp_q.size() == 0) chk(1, 0);
      else chk(erase_page, exp_q.pop_front());
    end
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    logic [23:0] a;
    logic [3:0] nd;
    bit al;
    sys_rst <= 1'h1;
    status_five <= 8'h00;
    page_protected <= 1'h0;
    erase_done <= 1'h0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    chk(status_byte_one, 0);
    chk(xip_dummy_clocks, 2);
    $display("test 1 done");
    a = 24'($random(seed));
    cmd(xpe_pkg::OP_PAGE_ERASE_A, a, 32);
    chk(busy_flag, 0);
    $display("test 2 done");
    cmd(xpe_pkg::OP_WRITE_ENABLE, 24'h00_0000, 8);
    chk(status_byte_one, 2);
    a = 24'($random(seed));
    exp_q.push_back(a[21:8]);
    cmd(xpe_pkg::OP_PAGE_ERASE_B, a, 32);
    chk(status_byte_one, 1);
    xpe_host_i.open();
    xpe_host_i.shift({xpe_pkg::OP_STATUS_IRQ, 32'h0000_0000}, 10, 1'h0);
    chk({spi_so_oe, spi_so_out}, 3);
    done_pulse();
    xpe_host_i.shift(40'h0, 3, 1'h0);
    chk({spi_so_oe, spi_so_out, busy_flag}, 4);
    xpe_host_i.close();
    chk(spi_so_oe, 0);
    $display("test 3 done");
    for (int k = 0; k < 5; k++) begin
      page_protected <= (k == 3);
      cmd(xpe_pkg::OP_WRITE_ENABLE, 24'h00_0000, 8);
      a = 24'($random(seed));
      if (k == 4) exp_q.push_back(a[21:8]);
      cmd(k[0] ? xpe_pkg::OP_PAGE_ERASE_B : xpe_pkg::OP_PAGE_ERASE_A, a, lens[k]);
      chk(busy_flag, k == 4);
    end
    done_pulse();
    $display("test 4 done");
    for (int k = 0; k < 16; k++) begin
      al = 1'($random(seed));
      a = 24'($random(seed));
      status_five <= {1'h0, k[2:0], 3'h0, al};
      nd = (k[2:0] > 4) ? 4'hA : {k[2:0], 1'h0} + 4'h2;
      xpe_host_i.open();
      xpe_host_i.shift({k[3] ? xpe_pkg::OP_XIP_READ_ALIGNED : xpe_pkg::OP_XIP_READ, 32'h0000_0000}, 8, 1'h0);
      xpe_host_i.shift({a, 16'h0000}, 6, 1'h1);
      xpe_host_i.shift(40'h0, nd - 1, 1'h1);
      chk(xip_dummy_clocks, nd);
      chk(xip_aligned, k[3] | al);
      chk(xip_addr, (k[3] | al) ? {a[23:2], 2'h0} : a);
      chk(xip_dummy_done, 0);
      xpe_host_i.shift(40'h0, 1, 1'h1);
      chk(xip_dummy_done, 1);
      chk({xip_active, xip_addr_valid}, 3);
      xpe_host_i.close();
      chk(xip_active, 0);
    end
    chk(exp_q.size(), 0);
    $display("test 5 done");
    conclude();
  end
endmodule // tb
bind xpe_sequencer xpe_seq_chk xpe_seq_chk_i (.sys_clk, .sys_rst, .spi_cs_n, .page_protected, .erase_done,
  .status_five, .erase_start, .erase_page, .busy_flag, .write_latch_flag, .xip_aligned, .xip_dummy_clocks,
  .xip_addr, .xip_addr_valid, .spi_so_out, .spi_so_oe);
`default_nettype wire

// ### testbench/xpe_host.sv
`timescale 1ns/1ns
`default_nettype none
module xpe_host (
  input wire logic sys_clk,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic [3:0] spi_io
);
  initial begin
    spi_sck = 1'h0;
    spi_cs_n = 1'h1;
    spi_io = 4'h0;
  end
  // 48 ns period stays under every listed limit, wrap mode too
  task automatic half();
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic open();
    @(posedge sys_clk);
    spi_cs_n <= 1'h0;
    half();
  endtask
  // MSB first; idle lines toggle so nothing reads as a held value
  task automatic shift(input logic [39:0] v, input int n, input bit quad);
    for (int i = 0; i < n; i++) begin
      spi_io <= quad ? v[39-4*i -: 4] : {~spi_io[3:1], v[39-i]};
      half();
      spi_sck <= 1'h1;
      half();
      spi_sck <= 1'h0;
    end
  endtask
  task automatic close();
    half();
    spi_cs_n <= 1'h1;
    spi_io <= ~spi_io;
    repeat (12) @(posedge sys_clk);
  endtask
endmodule // xpe_host
`default_nettype wire

// ### testbench/xpe_seq_chk.sv
`timescale 1ns/1ns
`default_nettype none
module xpe_seq_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic page_protected,
  input wire logic erase_done,
  input wire logic [7:0] status_five,
  input wire logic erase_start,
  input wire logic [xpe_pkg::PAGE_W-1:0] erase_page,
  input wire logic busy_flag,
  input wire logic write_latch_flag,
  input wire logic xip_aligned,
  input wire logic [3:0] xip_dummy_clocks,
  input wire logic [xpe_pkg::ADDR_W-1:0] xip_addr,
  input wire logic xip_addr_valid,
  input wire logic spi_so_out,
  input wire logic spi_so_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Reserved codes fall back to the largest count
  function automatic logic [3:0] dmap(input logic [2:0] c);
    return (c > 3'h4) ? 4'hA : {c, 1'h0} + 4'h2;
  endfunction
  sequence s_addr_in;
    $rose(xip_addr_valid);
  endsequence
  a_erase_latch: assert property (erase_start |-> $past(write_latch_flag) && !$past(busy_flag))
    else $error("erase without latch");
  a_erase_frame: assert property (erase_start |-> spi_cs_n && !page_protected)
    else $error("erase outside frame end");
  a_erase_effect: assert property (erase_start |=> !erase_start && busy_flag && !write_latch_flag)
    else $error("erase effect wrong");
  a_busy_hold: assert property (busy_flag && !erase_done |=> busy_flag)
    else $error("busy dropped early");
  a_page_hold: assert property (!erase_start |-> $stable(erase_page))
    else $error("page index moved");
  a_dummy_map: assert property (s_addr_in |-> xip_dummy_clocks == dmap(status_five[6:4]))
    else $error("dummy count wrong");
  a_aligned_addr: assert property (s_addr_in ##0 xip_aligned |-> ##1 xip_addr[1:0] == 2'h0)
    else $error("aligned low bits set");
  a_so_refresh: assert property (spi_so_oe && spi_so_out != busy_flag |-> ##[1:20] (spi_so_out == busy_flag || !spi_so_oe))
    else $error("busy not refreshed on pin");
endmodule // xpe_seq_chk
`default_nettype wire
